//--- sep_eeprom.v
// serial eeprom command port: decoder, array, read stream and busy timer
// Functional notes
// - instructions are 11 bits x16, 12 bits x8
// - sample input bits on serial clock rise
// - output floats except reading or busy status
// - status shows low busy, high ready
// - dummy one bit floats status output
// - opcode 10 reads the addressed word
// - opcode 11 erases the addressed word
// - opcode 01 writes one data word
// - opcode 00 subcodes unlock, lock, clear, fill
// - read sends dummy zero then MSB first
// - read bits change on serial clock rise
// - continued clocking reads the next word
// - sequential read wraps to address zero
// - only first word gets dummy zero
// - writes locked at power-up until unlocked
// - program cycle starts on select falling edge
// - erased reads ones; write auto-clears first (here a write overwrites the word directly, no clear)
`timescale 1ns/1ps
`default_nettype none
`include "sep_defines.vh"
module sep_eeprom
#(
  parameter PROG_CYCLES = `SEP_PROG_CYCLES
)
(
  // clock and reset
  input  wire i_mclk,
  input  wire i_rst,
  // serial pins, asynchronous to i_mclk
  input  wire i_chip_select,
  input  wire i_serial_clock_in,
  input  wire i_serial_data_in,
  input  wire i_word_width_select,
  // serial output with enable
  output reg  o_serial_data_out,
  output reg  o_serial_data_oe,
  // status
  output wire o_busy
);
  // sequencer states; ST_DONE and ST_WAIT park until chip select drops
  // so stray serial clocks after a complete instruction are ignored
  localparam ST_IDLE   = 3'h0;
  localparam ST_CMD    = 3'h1;
  localparam ST_READ   = 3'h2;
  localparam ST_WAIT   = 3'h3;
  localparam ST_STATUS = 3'h4;
  localparam ST_DONE   = 3'h5;

  // synchronised pins and their edges, all two flops behind the pins
  wire cs;
  wire cs_rise;
  wire cs_fall;
  wire sk_rise;
  wire di;
  wire wide;

  // instruction capture, write latch and self-timed cycle state
  // write_en survives deselect; only a lock instruction or reset clears it
  reg  [2:0]  state;
  reg  [4:0]  bit_cnt;
  reg  [1:0]  opcode;
  reg  [8:0]  addr;
  reg  [15:0] wdata;
  reg  [15:0] shift;
  reg         write_en;
  reg         pend;
  reg  [2:0]  pend_kind;
  reg  [31:0] timer;
  reg  [9:0]  fill_idx;
  // byte store: a wide word is an even/odd byte pair, high byte even
  reg  [7:0]  mem [0:`SEP_MEM_BYTES-1];

  // synchronise every pin before use
  sep_sync u_cs (.i_mclk(i_mclk), .i_rst(i_rst), .i_async(i_chip_select),
                 .o_level(cs), .o_rise(cs_rise), .o_fall(cs_fall));
  sep_sync u_sk (.i_mclk(i_mclk), .i_rst(i_rst), .i_async(i_serial_clock_in),
                 .o_level(), .o_rise(sk_rise), .o_fall());
  sep_sync u_di (.i_mclk(i_mclk), .i_rst(i_rst), .i_async(i_serial_data_in),
                 .o_level(di), .o_rise(), .o_fall());
  sep_sync u_ws (.i_mclk(i_mclk), .i_rst(i_rst), .i_async(i_word_width_select),
                 .o_level(wide), .o_rise(), .o_fall());

  // bits after the start bit: opcode plus address, then data
  wire [4:0] hdr_bits  = wide ? 5'h0A : 5'h0B;
  wire [4:0] word_bits = wide ? 5'h10 : 5'h08;
  // address as it stands once the bit now arriving is shifted in
  wire [8:0] next_addr_in = wide ? {1'b0, addr[6:0], di} : {addr[7:0], di};
  // subcode of opcode 00 lives in the two top address bits
  wire [1:0] next_sub  = wide ? next_addr_in[7:6] : next_addr_in[8:7];
  // decided on the last address bit: only write and fill carry a data word
  wire       need_data = (opcode == `SEP_OP_WRITE) ||
                         (opcode == `SEP_OP_SPECIAL && next_sub == `SEP_SUB_FILL);
  // busy is decoded from the timer so it drops the cycle the count ends
  assign o_busy = (timer != 32'h0);

  // fetch a word at an address, byte address formed per organisation
  // x8 bytes are returned left-aligned so the shifter needs no width mux
  function [15:0] rd_word;
    input [8:0] a;
    input       w;
    begin
      if (w)
        rd_word = {mem[{a[7:0], 1'b0}], mem[{a[7:0], 1'b1}]};
      else
        rd_word = {mem[a], 8'h00};
    end
  endfunction

  // pending operation kinds
  // PK_WORD and PK_ERASE touch one location; CLEAR and FILL walk all
  localparam PK_WORD  = 3'h1;
  localparam PK_ERASE = 3'h2;
  localparam PK_CLEAR = 3'h3;
  localparam PK_FILL  = 3'h4;

  // a single-word store and a whole-array walk never overlap: the walk
  // only starts from the same deselect edge and owns the cycles after it
  // array write: the whole-array kinds walk one byte per cycle while busy
  always @(posedge i_mclk)
  begin
    if (fill_idx < `SEP_MEM_BYTES)
    begin
      if (pend_kind == PK_FILL)
        mem[fill_idx[8:0]] <= (wide && fill_idx[0]) ? wdata[7:0]
                              : (wide ? wdata[15:8] : wdata[7:0]);
      else
        mem[fill_idx[8:0]] <= `SEP_ERASED_BYTE;
    end
    else if (state == ST_WAIT && cs_fall && pend)
    begin
      // single word store overwrites; no separate clear needed
      if (wide)
      begin
        mem[{addr[7:0], 1'b0}] <= (pend_kind == PK_WORD) ? wdata[15:8] : `SEP_ERASED_BYTE;
        mem[{addr[7:0], 1'b1}] <= (pend_kind == PK_WORD) ? wdata[7:0] : `SEP_ERASED_BYTE;
      end
      else
        mem[addr] <= (pend_kind == PK_WORD) ? wdata[7:0] : `SEP_ERASED_BYTE;
    end
  end

  // command sequencer
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state             <= ST_IDLE;
      bit_cnt           <= 5'h00;
      opcode            <= 2'h0;
      addr              <= 9'h000;
      wdata             <= 16'h0000;
      shift             <= 16'h0000;
      write_en          <= 1'b0;
      pend              <= 1'b0;
      pend_kind         <= 3'h0;
      timer             <= 32'h0;
      fill_idx          <= 10'h200;
      o_serial_data_out <= 1'b0;
      o_serial_data_oe  <= 1'b0;
    end
    else
    begin
      // self-timed cycle runs without serial clocks
      if (timer != 32'h0)
        timer <= timer - 32'h1;
      // walk index parks at the array size when no whole-array cycle runs
      if (fill_idx < `SEP_MEM_BYTES)
        fill_idx <= fill_idx + 10'h1;
      if (!cs)
      begin
        // deselect abandons any partial instruction
        if (cs_fall && state == ST_WAIT && pend)
        begin
          timer <= PROG_CYCLES;
          if (pend_kind == PK_CLEAR || pend_kind == PK_FILL)
            fill_idx <= 10'h000;
        end
        pend             <= 1'b0;
        state            <= ST_IDLE;
        o_serial_data_oe <= 1'b0;
      end
      // selecting the part during a cycle turns the pin into a status flag
      else if (cs_rise && o_busy)
      begin
        // status report while the cycle runs
        state             <= ST_STATUS;
        o_serial_data_oe  <= 1'b1;
        o_serial_data_out <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            bit_cnt <= 5'h00;
            // zeros before the start bit are idle clocks and are skipped
            if (sk_rise && di && !o_busy)
              state <= ST_CMD;
          end
          ST_STATUS:
          begin
            // the level follows the timer, so ready shows without new clocks
            o_serial_data_out <= ~o_busy;
            if (sk_rise && di)
            begin
              o_serial_data_oe <= 1'b0;
              state            <= ST_DONE;
            end
          end
          ST_CMD:
          begin
            if (sk_rise)
            begin
              bit_cnt <= bit_cnt + 5'h01;
              if (bit_cnt < 5'h02)
                opcode <= {opcode[0], di};
              else if (bit_cnt < hdr_bits)
                addr <= next_addr_in;
              else
                wdata <= {wdata[14:0], di};
              if (bit_cnt == hdr_bits - 5'h01 && opcode == `SEP_OP_READ)
              begin
                // dummy zero leads the first word
                shift             <= rd_word(next_addr_in, wide);
                o_serial_data_oe  <= 1'b1;
                o_serial_data_out <= 1'b0;
                bit_cnt           <= 5'h00;
                state             <= ST_READ;
              end
              // header-only commands end on the last address bit, others after data
              else if ((bit_cnt == hdr_bits - 5'h01 && !need_data) ||
                       (bit_cnt == hdr_bits + word_bits - 5'h01))
              begin
                state <= ST_WAIT;
                if (opcode == `SEP_OP_ERASE)
                begin
                  pend      <= write_en;
                  pend_kind <= PK_ERASE;
                end
                else if (opcode == `SEP_OP_WRITE)
                begin
                  pend      <= write_en;
                  pend_kind <= PK_WORD;
                end
              end
            end
            // opcode 00 needs the address before the subcode is known
            if (sk_rise && opcode == `SEP_OP_SPECIAL && bit_cnt == hdr_bits - 5'h01)
            begin
              case (next_sub)
                `SEP_SUB_UNLOCK: write_en <= 1'b1;
                `SEP_SUB_LOCK:   write_en <= 1'b0;
                `SEP_SUB_CLEAR:
                begin
                  pend      <= write_en;
                  pend_kind <= PK_CLEAR;
                end
                default:
                begin
                  // fill: the data word still follows, pend is set after it
                  pend_kind <= PK_FILL;
                end
              endcase
            end
            if (sk_rise && opcode == `SEP_OP_SPECIAL && pend_kind == PK_FILL &&
                bit_cnt == hdr_bits + word_bits - 5'h01)
              pend <= write_en;
          end
          ST_READ:
          begin
            if (sk_rise)
            begin
              // narrow words sit left-aligned in shift, so bit 15 is always next
              o_serial_data_out <= shift[15];
              shift   <= {shift[14:0], 1'b0};
              bit_cnt <= bit_cnt + 5'h01;
              if (bit_cnt == word_bits - 5'h01)
              begin
                // next word without dummy bit, wrapping
                addr    <= wide ? {1'b0, addr[7:0] + 8'h01} : addr + 9'h001;
                shift   <= rd_word(wide ? {1'b0, addr[7:0] + 8'h01} : addr + 9'h001, wide);
                bit_cnt <= 5'h00;
              end
            end
          end
          default:
          begin
            // wait, done: hold until deselect; a running cycle needs no clocks
            state <= state;
          end
        endcase
      end
    end
  end
endmodule // sep_eeprom
`default_nettype wire

//--- sep_defines.vh
// constants for the serial eeprom command port
`ifndef SEP_DEFINES_VH
`define SEP_DEFINES_VH
`define SEP_MEM_BYTES      512
`define SEP_ABITS_X16      8
`define SEP_ABITS_X8       9
`define SEP_DBITS_X16      16
`define SEP_DBITS_X8       8
`define SEP_OP_SPECIAL     2'h0
`define SEP_OP_WRITE       2'h1
`define SEP_OP_READ        2'h2
`define SEP_OP_ERASE       2'h3
`define SEP_SUB_LOCK       2'h0
`define SEP_SUB_FILL       2'h1
`define SEP_SUB_CLEAR      2'h2
`define SEP_SUB_UNLOCK     2'h3
`define SEP_CLK_MHZ        250
`define SEP_PROG_TIME_US   4000
`define SEP_PROG_CYCLES    (`SEP_PROG_TIME_US * `SEP_CLK_MHZ)
`define SEP_ERASED_BYTE    8'hFF
`endif

//--- sep_sync.v
// two-flop synchroniser with rising and falling edge detect on the synchronised level
`timescale 1ns/1ps
`default_nettype none
module sep_sync
(
  // clock and reset
  input  wire i_mclk,
  input  wire i_rst,
  // asynchronous level in
  input  wire i_async,
  // synchronised level and edges
  output reg  o_level,
  output wire o_rise,
  output wire o_fall
);
  reg meta;
  reg last;

  // first flop is read only by the second one
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta    <= 1'b0;
      o_level <= 1'b0;
      last    <= 1'b0;
    end
    else
    begin
      meta    <= i_async;
      o_level <= meta;
      last    <= o_level;
    end
  end

  assign o_rise = o_level & ~last;
  assign o_fall = ~o_level & last;
endmodule // sep_sync
`default_nettype wire

//--- sep_port_chk_sva.sv
// assertions on the serial eeprom port pins
`timescale 1ns/1ps
`default_nettype none
module sep_port_chk
#(
  parameter PROG_CYCLES = 2000
)
(
  // watched pins
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_chip_select,
  input wire logic i_serial_clock_in,
  input wire logic o_serial_data_out,
  input wire logic o_serial_data_oe,
  input wire logic o_busy
);
  int unsigned run;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // length of the current busy run
  always @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      run <= 0;
    else
      run <= o_busy ? run + 1 : 0;
  a_float_desel: assert property ($fell(i_chip_select) |-> ##[1:6] !o_serial_data_oe)
    else $error("drive after deselect");
  a_float_idle: assert property (!i_chip_select [*6] |-> !o_serial_data_oe)
    else $error("drive while idle");
  a_enable_low: assert property ($rose(o_serial_data_oe) |-> !o_serial_data_out)
    else $error("enabled with a one");
  // bits only move after an sk rise
  a_out_holds: assert property ((!i_serial_clock_in && !o_busy && o_serial_data_oe) [*8]
    |-> $stable(o_serial_data_out)) else $error("bit moved without sk");
  a_busy_max: assert property (run <= PROG_CYCLES)
    else $error("busy too long");
  a_busy_desel: assert property ($rose(o_busy) |-> !i_chip_select)
    else $error("cycle began while selected");
  a_busy_low: assert property (o_busy && o_serial_data_oe |-> !o_serial_data_out)
    else $error("ready shown while busy");
  a_ready_high: assert property ($fell(o_busy) && o_serial_data_oe |-> ##[1:8] o_serial_data_out)
    else $error("ready not shown");
endmodule // sep_port_chk
bind sep_eeprom sep_port_chk #(.PROG_CYCLES(PROG_CYCLES)) chk (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_chip_select(i_chip_select), .i_serial_clock_in(i_serial_clock_in),
  .o_serial_data_out(o_serial_data_out), .o_serial_data_oe(o_serial_data_oe), .o_busy(o_busy));
`default_nettype wire

//--- sep_host.sv
// host model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module sep_host
(
  // clock and device output
  input  wire logic i_mclk,
  input  wire logic i_do,
  // serial pins
  output var  logic o_cs,
  output var  logic o_sk,
  output var  logic o_di
);
  logic q;
  // sk stands still low outside frames
  initial {o_cs, o_sk, o_di} = 3'h0;
  // one 48 ns sk period; output sampled late so it has settled
  task automatic xfer(input logic d, output logic r);
    o_di <= d;
    repeat (6) @(posedge i_mclk);
    o_sk <= 1'b1;
    repeat (6) @(posedge i_mclk);
    r = i_do;
    o_sk <= 1'b0;
  endtask
  // n bits, msb first
  task automatic send(input int n, input logic [26:0] v);
    for (int i = n - 1; i >= 0; i--)
      xfer(v[i], q);
  endtask
  task automatic sel;
    @(posedge i_mclk);
    o_cs <= 1'b1;
    repeat (4) @(posedge i_mclk);
  endtask
  // low well past the minimum; di is not left at its last value
  task automatic desel;
    @(posedge i_mclk);
    o_cs <= 1'b0;
    o_di <= ~o_di;
    repeat (30) @(posedge i_mclk);
  endtask
endmodule // sep_host
`default_nettype wire

//--- sep_tb.sv
// self-checking testbench for the serial eeprom port
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int PROG = 2000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic word_width_select = 1'b1;
  logic q;
  int   failures = 0;
  int   tests_run = 0;
  wire logic cs, sk, di, dout, oe, busy;
  sep_eeprom #(.PROG_CYCLES(PROG)) uut (.i_mclk(mclk), .i_rst(rst), .i_chip_select(cs),
    .i_serial_clock_in(sk), .i_serial_data_in(di), .i_word_width_select(word_width_select),
    .o_serial_data_out(dout), .o_serial_data_oe(oe), .o_busy(busy));
  sep_host h (.i_mclk(mclk), .i_do(dout), .o_cs(cs), .o_sk(sk), .o_di(di));
  always #2 mclk = ~mclk;
  task automatic conclude;
    $display("checks %0d bad %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // bounded wait; the bound also caps the cycle length
  task automatic wait_ready;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < PROG + 50)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= PROG + 50)
    begin
      failures++;
      conclude();
    end
  endtask
  // command, deselect, then poll status if a cycle is expected
  task automatic prog(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d,
                      input logic wr, input logic ex);
    h.sel();
    h.send(11, {1'b1, op, a});
    if (wr)
      h.send(16, d);
    h.desel();
    chk(ex, busy);
    if (ex)
    begin
      h.sel();
      chk(2'h2, {oe, dout});
      wait_ready();
      repeat (8) @(posedge mclk);
      chk(2'h3, {oe, dout});
      h.xfer(1'b1, q);
      chk(1'b0, oe);
      h.desel();
    end
  endtask
  // two words read on from a
  task automatic rd2(input logic [7:0] a, input logic [15:0] e0, input logic [15:0] e1);
    logic [15:0] w;
    h.sel();
    h.send(11, {3'h6, a});
    chk(2'h2, {oe, dout});
    for (int k = 0; k < 32; k++)
    begin
      h.xfer(1'b0, q);
      w = {w[14:0], q};
      if (k == 15)
        chk(e0, w);
    end
    chk(e1, w);
    h.desel();
    chk(1'b0, oe);
  endtask
  // unlock, clear all, read across the top
  task automatic t_clear;
    prog(2'h1, 8'h10, 16'h1234, 1'b1, 1'b0);
    prog(2'h0, 8'hC0, 16'h0, 1'b0, 1'b0);
    prog(2'h0, 8'h80, 16'h0, 1'b0, 1'b1);
    rd2(8'hFF, 16'hFFFF, 16'hFFFF);
    $display("clear done");
  endtask
  // overwrite without erase, wrap read, erase one word
  task automatic t_write;
    prog(2'h1, 8'hFF, 16'hA5C3, 1'b1, 1'b1);
    prog(2'h1, 8'hFF, 16'h5A3C, 1'b1, 1'b1);
    prog(2'h1, 8'h00, 16'h0F0F, 1'b1, 1'b1);
    rd2(8'hFF, 16'h5A3C, 16'h0F0F);
    prog(2'h3, 8'h00, 16'h0, 1'b0, 1'b1);
    rd2(8'hFF, 16'h5A3C, 16'hFFFF);
    $display("write done");
  endtask
  // fill all, lock, refused write, abandoned command
  task automatic t_fill;
    prog(2'h0, 8'h40, 16'h3C96, 1'b1, 1'b1);
    prog(2'h0, 8'h00, 16'h0, 1'b0, 1'b0);
    prog(2'h1, 8'h7F, 16'h0, 1'b1, 1'b0);
    h.sel();
    h.send(4, 27'hD);
    h.desel();
    rd2(8'h7F, 16'h3C96, 16'h3C96);
    $display("fill done");
  endtask
  // byte organisation: unlock, write the top byte, read across the wrap
  task automatic t_narrow;
    logic [15:0] w;
    word_width_select <= 1'b0;
    repeat (8) @(posedge mclk);
    h.sel();
    h.send(12, {3'h4, 9'h180});
    h.desel();
    h.sel();
    h.send(12, {3'h5, 9'h1FF});
    h.send(8, 8'h6B);
    h.desel();
    chk(1'b1, busy);
    wait_ready();
    repeat (40) @(posedge mclk);
    h.sel();
    h.send(12, {3'h6, 9'h1FF});
    chk(2'h2, {oe, dout});
    for (int k = 0; k < 16; k++)
    begin
      h.xfer(1'b0, q);
      w = {w[14:0], q};
    end
    chk(16'h6B3C, w);
    h.desel();
    $display("narrow done");
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (250) @(posedge mclk);
    chk(2'h0, {oe, busy});
    t_clear();
    t_write();
    t_fill();
    t_narrow();
    conclude();
  end
endmodule // tb
`default_nettype wire
